// *** flash_program_erase_command_fsm_bench.sv ***
`timescale 1ns/1ps
module flash_program_erase_command_fsm_bench;
	typedef struct packed {logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] m; logic [31:0] e;} fpc_row_s;
	logic        ref_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0]  reg_addr  = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic [21:0] flash_addr;
	logic [15:0] dq_in, dq_out;
	logic        dq_oe, chip_select_zero_n, chip_select_one_n, chip_select_two_n;
	logic        output_enable_n, write_enable_n, reset_powerdown_pin_n, ready_pulse_pin;
	int          errors = 0, check_count = 0;
	fpc_row_s rows [] = '{
		'{8'h04, 32'h100, 8'h0, 32'h0, 32'h0}, '{8'h08, 32'h1234, 8'h0, 32'h0, 32'h0},
		'{8'h00, 32'h4, 8'h0, 32'h0, 32'h0}, '{8'h00, 32'hb, 8'h14, 32'hff, 32'h80},
		'{8'h00, 32'h0, 8'h18, 32'hffff, 32'h1234}, '{8'h00, 32'h3, 8'h0, 32'h0, 32'h0},
		'{8'h00, 32'h6, 8'h00, 32'h8, 32'h8}, '{8'h00, 32'h7, 8'h00, 32'hc, 32'h4},
		'{8'h00, 32'h0, 8'h00, 32'h2, 32'h2}, '{8'h00, 32'hb, 8'h14, 32'hff, 32'h80},
		'{8'h00, 32'h0, 8'h18, 32'hffff, 32'hffff}, '{8'h00, 32'h8, 8'h0, 32'h0, 32'h0},
		'{8'h00, 32'hb, 8'h14, 32'hff, 32'h80}, '{8'h00, 32'h4, 8'h0, 32'h0, 32'h0},
		'{8'h00, 32'hb, 8'h14, 32'hff, 32'h90}, '{8'h00, 32'h0, 8'h18, 32'hffff, 32'hffff},
		'{8'h00, 32'h9, 8'h0, 32'h0, 32'h0}, '{8'h00, 32'hb, 8'h14, 32'hff, 32'h90},
		'{8'h04, 32'h200, 8'h0, 32'h0, 32'h0},
		'{8'h0c, 32'h1, 8'h0, 32'h0, 32'h0}, '{8'h10, 32'haaaa, 8'h0, 32'h0, 32'h0},
		'{8'h10, 32'h5555, 8'h0c, 32'h1ff, 32'h21}, '{8'h00, 32'h5, 8'h0, 32'h0, 32'h0},
		'{8'h00, 32'hb, 8'h14, 32'hff, 32'h80}, '{8'h00, 32'h0, 8'h18, 32'hffff, 32'haaaa},
		'{8'h04, 32'h202, 8'h0, 32'h0, 32'h0}, '{8'h00, 32'h0, 8'h18, 32'hffff, 32'h5555},
		'{8'h00, 32'hc, 8'h00, 32'h2, 32'h2}, '{8'h00, 32'h1, 8'h00, 32'h2, 32'h0},
		'{8'h40, 32'h5, 8'h40, 32'hffffffff, 32'h0}};
	fpc_host dut_u (.*);
	fpc_dev_model dev_u (.*);
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task end_sim;
		if (errors == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] q);
		@(posedge ref_clk);
		reg_rd <= 1'b1; reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 q = reg_rdata;
	endtask
	// Busy covers the whole pin sequence, so each row waits on it with a bound.
	task idle;
		logic [31:0] q;
		for (int i = 0; i < 3000; i++) begin
			rd(8'h00, q);
			if (q[0] === 1'b0) return;
		end
		errors++;
		end_sim();
	endtask
	initial forever #4 ref_clk = ~ref_clk;
	initial begin
		logic [31:0] q;
		repeat (2) @(posedge ref_clk);
		chk(reg_rdata, 32'h0);
		chk({25'h0, dq_oe, chip_select_zero_n, chip_select_one_n, chip_select_two_n, output_enable_n,
			reset_powerdown_pin_n, write_enable_n}, 32'h3d);
		reset <= 1'b0;
		idle();
		foreach (rows[i]) begin
			wr(rows[i].wa, rows[i].wd);
			idle();
			if (rows[i].m != 32'h0) begin
				rd(rows[i].ra, q);
				chk(q & rows[i].m, rows[i].e);
			end
		end
		// Reset one cycle after an erase is accepted, before any erase write, must bring the array back in read mode.
		wr(8'h00, 32'h3);
		reset <= 1'b1;
		repeat (2) @(posedge ref_clk);
		chk({31'h0, reset_powerdown_pin_n}, 32'h0);
		reset <= 1'b0;
		idle();
		wr(8'h00, 32'h0);
		idle();
		rd(8'h18, q);
		chk(q & 32'hffff, 32'hffff);
		end_sim();
	end
endmodule // flash_program_erase_command_fsm_bench

// *** fpc_buf_if.sv ***
`timescale 1ns/1ps
interface fpc_buf_if #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
);
	localparam int AW = $clog2(DEPTH);
	logic             wr_en;
	logic [AW-1:0]    wr_idx;
	logic [WIDTH-1:0] wr_data;
	logic [AW-1:0]    rd_idx;
	logic [WIDTH-1:0] rd_data;
	modport ctl (output wr_en, wr_idx, wr_data, rd_idx, input rd_data);
	modport mem (input wr_en, wr_idx, wr_data, rd_idx, output rd_data);
endinterface

// *** fpc_buf_mem.sv ***
`timescale 1ns/1ps
module fpc_buf_mem #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic ref_clk,
	fpc_buf_if.mem   bus
);
	logic [WIDTH-1:0] mem_reg [DEPTH];

	// Read data always leave a register, one cycle after the index.
	always_ff @(posedge ref_clk) begin
		if (bus.wr_en) begin
			mem_reg[bus.wr_idx] <= bus.wr_data;
		end
		bus.rd_data <= mem_reg[bus.rd_idx];
	end
endmodule // fpc_buf_mem

// *** fpc_defines.svh ***
`ifndef FPC_DEFINES_SVH
`define FPC_DEFINES_SVH

// ----------------------------------------
// Controller register offsets
// ----------------------------------------
`define FPC_REG_CMD      8'h00
`define FPC_REG_ADDR     8'h04
`define FPC_REG_DATA     8'h08
`define FPC_REG_COUNT    8'h0c
`define FPC_REG_BUFW     8'h10
`define FPC_REG_DSTAT    8'h14
`define FPC_REG_RDATA    8'h18

// ----------------------------------------
// Device command codes
// ----------------------------------------
`define FPC_CMD_READ_ARRAY  8'hff
`define FPC_CMD_READ_STATUS 8'h70
`define FPC_CMD_CLEAR       8'h50
`define FPC_CMD_ERASE       8'h20
`define FPC_CMD_PROGRAM     8'h40
`define FPC_CMD_BUF_PROGRAM 8'he8
`define FPC_CMD_CONFIRM     8'hd0
`define FPC_CMD_SUSPEND     8'hb0
`define FPC_CMD_PROTECT     8'h60
`define FPC_CMD_PROT_CONF   8'h01
`define FPC_CMD_PREG        8'hc0

// ----------------------------------------
// Device status byte fields
// ----------------------------------------
`define FPC_SB_IDLE      7
`define FPC_SB_ESUSP     6
`define FPC_SB_PSUSP     2
`define FPC_SB_ERR_MASK  8'h3a

// ----------------------------------------
// Pin timing, in ns and in clock cycles
// ----------------------------------------
`define FPC_CLK_NS       8
`define FPC_T_WP_NS      100
`define FPC_T_WH_NS      30
`define FPC_T_RD_NS      120
`define FPC_T_RST_NS     1000
`define FPC_WP_CYC       ((`FPC_T_WP_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)
`define FPC_WH_CYC       ((`FPC_T_WH_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)
`define FPC_RD_CYC       ((`FPC_T_RD_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS + 2)
`define FPC_RST_CYC      ((`FPC_T_RST_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)

`endif

// *** fpc_dev_model.sv ***
`timescale 1ns/1ps
module fpc_dev_model (
	input  wire logic [21:0] flash_addr,
	input  wire logic [15:0] dq_out,
	output logic      [15:0] dq_in,
	input  wire logic        chip_select_zero_n,
	input  wire logic        output_enable_n,
	input  wire logic        write_enable_n,
	input  wire logic        reset_powerdown_pin_n,
	output logic             ready_pulse_pin
);
	logic [15:0] mem [int];
	logic [15:0] last = 16'h0000;
	logic [7:0]  sr   = 8'h80;
	logic [7:0]  pend = 8'h00;
	logic        smd  = 1'b0;
	logic        ers  = 1'b0;
	bit          prot [int];
	int          left = 0;
	assign ready_pulse_pin = sr[7];
	// Busy lasts 200 ns, an erase 2000 ns so that a suspend can still catch it.
	task automatic go(input logic e);
		ers   = e;
		sr[7] = 1'b0;
		if (e) sr[7] <= #2000 1'b1;
		else sr[7] <= #200 1'b1;
	endtask
	always @(negedge reset_powerdown_pin_n) begin
		pend = 8'h00;
		smd = 1'b0;
	end
	always @(posedge write_enable_n) if (!chip_select_zero_n && reset_powerdown_pin_n) begin
		case (pend)
			8'h20: begin
				if (dq_out[7:0] == 8'hd0) begin
					if (prot.exists(int'(flash_addr) >> 17)) sr[5] = 1'b1;
					else mem.delete();
					go(1'b1);
				end
				pend = 8'h00;
			end
			8'h40: begin
				if (prot.exists(int'(flash_addr) >> 17)) sr[4] = 1'b1;
				else mem[int'(flash_addr)] = dq_out;
				go(1'b0);
				pend = 8'h00;
			end
			8'h60: begin
				if (dq_out[7:0] == 8'h01) prot[int'(flash_addr) >> 17] = 1'b1;
				if (dq_out[7:0] == 8'hd0) prot.delete();
				go(1'b0);
				pend = 8'h00;
			end
			8'he8: begin
				left = int'(dq_out) + 1;
				pend = 8'he9;
			end
			8'he9: if (left > 0) begin
				mem[int'(flash_addr)] = dq_out;
				left--;
			end else begin
				go(1'b0);
				pend = 8'h00;
			end
			default: if (sr[7] || dq_out[7:0] inside {8'h70, 8'hb0}) begin
				smd = dq_out[7:0] != 8'hff;
				if (dq_out[7:0] == 8'h50) sr = sr & ~8'h3a;
				// A suspend pauses at once; the erase timer keeps running, so a resume only waits for it.
				if (dq_out[7:0] == 8'hb0 && !sr[7]) sr = sr | (ers ? 8'hc0 : 8'h84);
				else if (dq_out[7:0] == 8'hd0 && (sr[6] || sr[2])) sr = sr & ~8'hc4;
				if (dq_out[7:0] inside {8'h20, 8'h40, 8'h60, 8'he8}) pend = dq_out[7:0];
			end
		endcase
	end
	// A released bus shows the inverse of the last value, never a stale copy.
	always @(output_enable_n, chip_select_zero_n, flash_addr, sr, smd) begin
		if (!chip_select_zero_n && !output_enable_n) begin
			dq_in = smd ? {8'h00, sr} : (mem.exists(int'(flash_addr)) ? mem[int'(flash_addr)] : 16'hffff);
			last = dq_in;
		end else dq_in = ~last;
	end
endmodule // fpc_dev_model

// *** fpc_host.sv ***
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "fpc_defines.svh"
// Notes on behaviour
// - Erase is two writes; second carries block address and starts the controller.
// - Word program is a setup write, then one write with address and data.
// - Buffer words share address bits above the buffer index.
// - Buffered program opens with a setup write to the target block.
// - Second buffered write gives count N; N plus one words follow.
// - N plus one word writes, then one confirm write starts programming.
// - Clear status before reissuing a buffered program that failed.
// - After suspend, poll the idle flag until the controller pauses.
// - After a program inside erase suspend, send read-array before resume.
// - During erase suspend, avoid the block being erased.
// - Protection register program is two writes and cannot be suspended.
module fpc_host #(
	parameter int BUF_DEPTH = 16,
	parameter int BLK_LSB   = 17
) (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output logic      [21:0] flash_addr,
	input  wire logic [15:0] dq_in,
	output logic      [15:0] dq_out,
	output logic             dq_oe,
	output logic             chip_select_zero_n,
	output logic             chip_select_one_n,
	output logic             chip_select_two_n,
	output logic             output_enable_n,
	output logic             write_enable_n,
	output logic             reset_powerdown_pin_n,
	input  wire logic        ready_pulse_pin
);
	localparam int IW = $clog2(BUF_DEPTH);

	// ----------------------------------------
	// State
	// ----------------------------------------
	fpc_pkg::fpc_state_e state_reg, state_next;
	fpc_pkg::fpc_op_e    op_reg, op_next;
	fpc_pkg::fpc_run_e   run_reg, run_next;
	logic [2:0]          seq_reg, seq_next;
	logic [7:0]          tmr_reg, tmr_next;
	logic [IW-1:0]       bidx_reg, bidx_next;
	logic [IW:0]         fill_reg, fill_next;
	logic [IW-1:0]       count_reg, count_next;
	logic [21:0]         addr_reg, addr_next;
	logic [21:0]         eblk_reg, eblk_next;
	logic [15:0]         data_reg, data_next;
	logic [15:0]         rdata_reg, rdata_next;
	logic [7:0]          stat_reg, stat_next;
	logic                esusp_reg, esusp_next;
	logic                psusp_reg, psusp_next;
	logic                pis_reg, pis_next;
	logic                flag_reg, flag_next;
	logic                refused_reg, refused_next;
	logic [31:0]         bus_rdata_reg;
	logic [21:0]         fa_reg;
	logic [15:0]         dqo_reg, dqo_next;
	logic                dqoe_reg, ce_n_reg, oe_n_reg, we_n_reg, rp_n_reg;
	logic [15:0]         dq_s1_reg, dq_s2_reg;
	logic                rdy_s1_reg, rdy_s2_reg;

	fpc_buf_if #(.WIDTH(16), .DEPTH(BUF_DEPTH)) buf_bus ();

	fpc_buf_mem #(.WIDTH(16), .DEPTH(BUF_DEPTH)) u_mem (
		.ref_clk (ref_clk),
		.bus     (buf_bus.mem)
	);

	// ----------------------------------------
	// Register port decode
	// ----------------------------------------
	wire                is_idle  = state_reg == fpc_pkg::ST_IDLE;
	wire                wr_cmd   = reg_wr && reg_addr == `FPC_REG_CMD;
	wire                wr_other = reg_wr && reg_addr != `FPC_REG_CMD;
	wire                wr_addr  = reg_wr && reg_addr == `FPC_REG_ADDR && is_idle;
	wire                wr_data  = reg_wr && reg_addr == `FPC_REG_DATA && is_idle;
	wire                wr_count = reg_wr && reg_addr == `FPC_REG_COUNT && is_idle;
	wire                buf_full = fill_reg == (IW + 1)'(BUF_DEPTH);
	wire                wr_bufw  = reg_wr && reg_addr == `FPC_REG_BUFW && is_idle && !buf_full;
	wire                bad_wr   = wr_other && !(wr_addr || wr_data || wr_count || wr_bufw);
	wire fpc_pkg::fpc_op_e wop   = fpc_pkg::fpc_op_e'(reg_wdata[3:0]);
	wire                op_valid = reg_wdata[3:0] <= 4'(fpc_pkg::OP_POLL);
	wire                no_run   = run_reg == fpc_pkg::RUN_NONE;
	wire                same_blk = addr_reg[21:BLK_LSB] == eblk_reg[21:BLK_LSB];
	wire                err_pend = |(stat_reg & `FPC_SB_ERR_MASK);
	wire                buf_ok   = fill_reg == {1'b0, count_reg} + (IW + 1)'(1);

	// Host-side gate: commands the device would ignore are never sent.
	// Every state the gate reads is an argument, so the continuous assignment below re-evaluates on it.
	function automatic logic op_ok(input fpc_pkg::fpc_op_e o, input fpc_pkg::fpc_run_e r, input logic es,
			input logic ps, input logic sb, input logic bo);
		logic nr;
		logic keep;
		nr   = r == fpc_pkg::RUN_NONE;
		keep = !(es && sb);
		case (o)
			fpc_pkg::OP_READ_STATUS, fpc_pkg::OP_POLL: op_ok = 1'b1;
			fpc_pkg::OP_READ_ARRAY: op_ok = nr && keep;
			fpc_pkg::OP_SUSPEND: op_ok = r == fpc_pkg::RUN_ERASE || r == fpc_pkg::RUN_PROG;
			fpc_pkg::OP_RESUME: op_ok = nr && (es || ps);
			fpc_pkg::OP_PROGRAM: op_ok = nr && !ps && keep;
			fpc_pkg::OP_BUF_PROGRAM: op_ok = nr && !ps && keep && bo;
			default: op_ok = nr && !(es || ps);
		endcase
	endfunction

	wire accept    = wr_cmd && is_idle && op_valid && op_ok(wop, run_reg, esusp_reg, psusp_reg, same_blk, buf_ok);
	wire refuse_ev = (wr_cmd && !accept) || bad_wr;

	// ----------------------------------------
	// Command sequences
	// ----------------------------------------
	function automatic fpc_pkg::fpc_step_s wc(input logic [7:0] c);
		return '{kind: fpc_pkg::K_WC, code: c};
	endfunction

	function automatic fpc_pkg::fpc_step_s kd(input fpc_pkg::fpc_kind_e k);
		return '{kind: k, code: 8'h00};
	endfunction

	function automatic fpc_pkg::fpc_step_s step_of(input fpc_pkg::fpc_op_e o, input logic [2:0] s,
			input logic f);
		fpc_pkg::fpc_step_s r;
		r = kd(fpc_pkg::K_END);
		case (o)
			fpc_pkg::OP_READ_ARRAY: r = s == 3'h0 ? wc(`FPC_CMD_READ_ARRAY) : s == 3'h1 ? kd(fpc_pkg::K_RD) : r;
			fpc_pkg::OP_READ_STATUS: r = s == 3'h0 ? wc(`FPC_CMD_READ_STATUS) : s == 3'h1 ? kd(fpc_pkg::K_RD) : r;
			fpc_pkg::OP_CLEAR_STATUS: r = s == 3'h0 ? wc(`FPC_CMD_CLEAR) : r;
			fpc_pkg::OP_ERASE: r = s == 3'h0 ? wc(`FPC_CMD_ERASE) : s == 3'h1 ? wc(`FPC_CMD_CONFIRM) : r;
			fpc_pkg::OP_PROGRAM: r = s == 3'h0 ? wc(`FPC_CMD_PROGRAM) : s == 3'h1 ? kd(fpc_pkg::K_WD) : r;
			fpc_pkg::OP_BUF_PROGRAM: begin
				case (s)
					3'h0: r = f ? wc(`FPC_CMD_CLEAR) : kd(fpc_pkg::K_SKIP);
					3'h1: r = wc(`FPC_CMD_BUF_PROGRAM);
					3'h2: r = kd(fpc_pkg::K_WN);
					3'h3: r = kd(fpc_pkg::K_WB);
					3'h4: r = wc(`FPC_CMD_CONFIRM);
					default: r = kd(fpc_pkg::K_END);
				endcase
			end
			fpc_pkg::OP_SUSPEND: r = s == 3'h0 ? wc(`FPC_CMD_SUSPEND) : s == 3'h1 ? kd(fpc_pkg::K_POLL) : r;
			fpc_pkg::OP_RESUME: begin
				case (s)
					3'h0: r = f ? wc(`FPC_CMD_READ_ARRAY) : kd(fpc_pkg::K_SKIP);
					3'h1: r = wc(`FPC_CMD_CONFIRM);
					default: r = kd(fpc_pkg::K_END);
				endcase
			end
			fpc_pkg::OP_PROTECT: r = s == 3'h0 ? wc(`FPC_CMD_PROTECT) : s == 3'h1 ? wc(`FPC_CMD_PROT_CONF) : r;
			fpc_pkg::OP_UNPROTECT: r = s == 3'h0 ? wc(`FPC_CMD_PROTECT) : s == 3'h1 ? wc(`FPC_CMD_CONFIRM) : r;
			fpc_pkg::OP_PREG_PROGRAM: r = s == 3'h0 ? wc(`FPC_CMD_PREG) : s == 3'h1 ? kd(fpc_pkg::K_WD) : r;
			fpc_pkg::OP_POLL: r = s == 3'h0 ? kd(fpc_pkg::K_POLL) : r;
			default: r = kd(fpc_pkg::K_END);
		endcase
		return r;
	endfunction

	wire fpc_pkg::fpc_step_s step = step_of(op_reg, seq_reg, flag_reg);
	wire        wp_done  = tmr_reg == 8'(`FPC_WP_CYC - 1);
	wire        wh_done  = tmr_reg == 8'(`FPC_WH_CYC - 1);
	wire        rd_done  = tmr_reg == 8'(`FPC_RD_CYC - 1);
	wire        rst_done = tmr_reg == 8'(`FPC_RST_CYC - 1);
	wire        buf_last = bidx_reg == count_reg;
	wire        is_wb    = step.kind == fpc_pkg::K_WB;
	wire        sampled  = state_reg == fpc_pkg::ST_RD && rd_done;
	wire        fin      = state_reg == fpc_pkg::ST_CMD && step.kind == fpc_pkg::K_END;
	wire [21:0] ld_addr  = is_wb ? {addr_reg[21:IW+1], bidx_reg, 1'b0} : addr_reg;
	wire [15:0] ld_data  = step.kind == fpc_pkg::K_WD ? data_reg :
		step.kind == fpc_pkg::K_WN ? 16'(count_reg) :
		is_wb ? buf_bus.rd_data : {8'h00, step.code};

	assign buf_bus.wr_en   = wr_bufw;
	assign buf_bus.wr_idx  = fill_reg[IW-1:0];
	assign buf_bus.wr_data = reg_wdata[15:0];
	assign buf_bus.rd_idx  = bidx_reg;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		seq_next   = seq_reg;
		tmr_next   = tmr_reg + 8'h01;
		bidx_next  = bidx_reg;
		case (state_reg)
			fpc_pkg::ST_RST: begin
				if (rst_done) begin
					state_next = fpc_pkg::ST_IDLE;
				end
			end
			fpc_pkg::ST_IDLE: begin
				tmr_next = 8'h00;
				if (accept) begin
					state_next = fpc_pkg::ST_CMD;
					seq_next   = 3'h0;
					bidx_next  = '0;
				end
			end
			fpc_pkg::ST_CMD: begin
				tmr_next = 8'h00;
				case (step.kind)
					fpc_pkg::K_END: state_next = fpc_pkg::ST_IDLE;
					fpc_pkg::K_SKIP: seq_next = seq_reg + 3'h1;
					fpc_pkg::K_RD, fpc_pkg::K_POLL: state_next = fpc_pkg::ST_RD;
					default: state_next = fpc_pkg::ST_LOAD;
				endcase
			end
			fpc_pkg::ST_LOAD: begin
				tmr_next   = 8'h00;
				state_next = fpc_pkg::ST_WLOW;
			end
			fpc_pkg::ST_WLOW: begin
				if (wp_done) begin
					tmr_next   = 8'h00;
					state_next = fpc_pkg::ST_WHIGH;
				end
			end
			fpc_pkg::ST_WHIGH: begin
				if (wh_done) begin
					state_next = fpc_pkg::ST_CMD;
					if (is_wb && !buf_last) begin
						bidx_next = bidx_reg + IW'(1);
					end else begin
						seq_next = seq_reg + 3'h1;
					end
				end
			end
			fpc_pkg::ST_RD: begin
				if (rd_done) begin
					state_next = fpc_pkg::ST_CMD;
					// A poll repeats its read until the controller reports idle.
					if (step.kind == fpc_pkg::K_RD || dq_s2_reg[`FPC_SB_IDLE]) begin
						seq_next = seq_reg + 3'h1;
					end
				end
			end
			default: state_next = fpc_pkg::ST_RST;
		endcase
	end

	// ----------------------------------------
	// Bookkeeping of the device's operation
	// ----------------------------------------
	always_comb begin
		run_next   = run_reg;
		esusp_next = esusp_reg;
		psusp_next = psusp_reg;
		pis_next   = pis_reg;
		eblk_next  = eblk_reg;
		stat_next  = sampled && (step.kind == fpc_pkg::K_POLL || op_reg == fpc_pkg::OP_READ_STATUS) ?
			dq_s2_reg[7:0] : stat_reg;
		if (fin) begin
			case (op_reg)
				fpc_pkg::OP_ERASE: begin
					run_next  = fpc_pkg::RUN_ERASE;
					eblk_next = addr_reg;
				end
				fpc_pkg::OP_PROGRAM, fpc_pkg::OP_BUF_PROGRAM: begin
					run_next = fpc_pkg::RUN_PROG;
					pis_next = pis_reg || esusp_reg;
				end
				fpc_pkg::OP_PROTECT, fpc_pkg::OP_UNPROTECT, fpc_pkg::OP_PREG_PROGRAM: begin
					run_next = fpc_pkg::RUN_LOCK;
				end
				fpc_pkg::OP_SUSPEND: begin
					// The operation may have finished instead of pausing.
					run_next = fpc_pkg::RUN_NONE;
					if (run_reg == fpc_pkg::RUN_ERASE) begin
						esusp_next = stat_reg[`FPC_SB_ESUSP];
					end else begin
						psusp_next = stat_reg[`FPC_SB_PSUSP];
					end
				end
				fpc_pkg::OP_RESUME: begin
					if (psusp_reg) begin
						run_next   = fpc_pkg::RUN_PROG;
						psusp_next = 1'b0;
					end else begin
						run_next   = fpc_pkg::RUN_ERASE;
						esusp_next = 1'b0;
						pis_next   = 1'b0;
					end
				end
				fpc_pkg::OP_POLL: run_next = fpc_pkg::RUN_NONE;
				fpc_pkg::OP_CLEAR_STATUS: stat_next = stat_reg & ~`FPC_SB_ERR_MASK;
				default: run_next = run_reg;
			endcase
		end
	end

	assign op_next      = accept ? wop : op_reg;
	assign flag_next    = accept ? (wop == fpc_pkg::OP_BUF_PROGRAM ? err_pend : pis_reg) : flag_reg;
	assign refused_next = refuse_ev ? 1'b1 : (wr_cmd ? 1'b0 : refused_reg);
	assign addr_next    = wr_addr ? reg_wdata[21:0] : addr_reg;
	assign data_next    = wr_data ? reg_wdata[15:0] : data_reg;
	assign count_next   = wr_count ? reg_wdata[IW-1:0] : count_reg;
	assign fill_next    = wr_count || (fin && op_reg == fpc_pkg::OP_BUF_PROGRAM) ? '0 :
		wr_bufw ? fill_reg + (IW + 1)'(1) : fill_reg;
	assign rdata_next   = sampled && step.kind == fpc_pkg::K_RD ? dq_s2_reg : rdata_reg;
	assign dqo_next     = state_reg == fpc_pkg::ST_LOAD ? ld_data : dqo_reg;

	wire [31:0] rd_mux =
		reg_addr == `FPC_REG_CMD ? {26'h0, pis_reg, psusp_reg, esusp_reg, !no_run, refused_reg, !is_idle} :
		reg_addr == `FPC_REG_ADDR ? {10'h0, addr_reg} :
		reg_addr == `FPC_REG_DATA ? {16'h0, data_reg} :
		reg_addr == `FPC_REG_COUNT ? 32'({fill_reg, count_reg}) :
		reg_addr == `FPC_REG_DSTAT ? {23'h0, rdy_s2_reg, stat_reg} :
		reg_addr == `FPC_REG_RDATA ? {16'h0, rdata_reg} : 32'h0;

	wire bus_on = state_next inside {fpc_pkg::ST_LOAD, fpc_pkg::ST_WLOW, fpc_pkg::ST_WHIGH};

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		dq_s1_reg  <= dq_in;
		dq_s2_reg  <= dq_s1_reg;
		rdy_s1_reg <= ready_pulse_pin;
		rdy_s2_reg <= rdy_s1_reg;
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_reg <= fpc_pkg::ST_RST;
			op_reg    <= fpc_pkg::OP_POLL;
			run_reg   <= fpc_pkg::RUN_NONE;
			{seq_reg, tmr_reg, bidx_reg, fill_reg, count_reg} <= '0;
			{addr_reg, eblk_reg, data_reg, rdata_reg, stat_reg} <= '0;
			{esusp_reg, psusp_reg, pis_reg, flag_reg, refused_reg} <= '0;
		end else begin
			state_reg <= state_next;
			op_reg    <= op_next;
			run_reg   <= run_next;
			{seq_reg, tmr_reg, bidx_reg, fill_reg, count_reg} <= {seq_next, tmr_next, bidx_next, fill_next, count_next};
			{addr_reg, eblk_reg, data_reg, rdata_reg, stat_reg} <= {addr_next, eblk_next, data_next, rdata_next, stat_next};
			{esusp_reg, psusp_reg, pis_reg, flag_reg, refused_reg} <=
				{esusp_next, psusp_next, pis_next, flag_next, refused_next};
		end
	end

	// Pin flops load from state_next on one edge, dq_out from state_reg in ST_LOAD; write enable falls a cycle after the address and rises before the select.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			{fa_reg, dqo_reg, dqoe_reg, bus_rdata_reg} <= '0;
			{ce_n_reg, oe_n_reg, we_n_reg, rp_n_reg} <= 4'he;
		end else begin
			fa_reg        <= state_next inside {fpc_pkg::ST_LOAD, fpc_pkg::ST_RD} ? ld_addr : fa_reg;
			dqo_reg       <= dqo_next;
			dqoe_reg      <= bus_on;
			ce_n_reg      <= !(bus_on || state_next == fpc_pkg::ST_RD);
			we_n_reg      <= state_next != fpc_pkg::ST_WLOW;
			oe_n_reg      <= state_next != fpc_pkg::ST_RD;
			rp_n_reg      <= state_next != fpc_pkg::ST_RST;
			bus_rdata_reg <= reg_rd ? rd_mux : 32'h0;
		end
	end

	assign reg_rdata             = bus_rdata_reg;
	assign flash_addr            = fa_reg;
	assign dq_out                = dqo_reg;
	assign dq_oe                 = dqoe_reg;
	assign chip_select_zero_n    = ce_n_reg;
	assign chip_select_one_n     = ce_n_reg;
	assign chip_select_two_n     = ce_n_reg;
	assign output_enable_n       = oe_n_reg;
	assign write_enable_n        = we_n_reg;
	assign reset_powerdown_pin_n = rp_n_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	logic [IW:0] wb_cnt_reg;
	always_ff @(posedge ref_clk) begin
		if (reset || accept) begin
			wb_cnt_reg <= '0;
		end else if ($rose(write_enable_n) && op_reg == fpc_pkg::OP_BUF_PROGRAM && seq_reg == 3'h3) begin
			wb_cnt_reg <= wb_cnt_reg + (IW + 1)'(1);
		end
	end

	sequence s_rise(fpc_pkg::fpc_op_e o, int s);
		$rose(write_enable_n) && op_reg == o && seq_reg == 3'(s);
	endsequence

	a_erase_confirm: assert property (s_rise(fpc_pkg::OP_ERASE, 1) |-> dq_out[7:0] == `FPC_CMD_CONFIRM
		&& flash_addr == addr_reg) else $error("erase second write wrong");
	a_prog_setup: assert property (s_rise(fpc_pkg::OP_PROGRAM, 0) ##[1:40] s_rise(fpc_pkg::OP_PROGRAM, 1)
		|-> dq_out == data_reg && flash_addr == addr_reg) else $error("program data write wrong");
	a_buf_upper: assert property (s_rise(fpc_pkg::OP_BUF_PROGRAM, 3)
		|-> flash_addr[21:IW+1] == addr_reg[21:IW+1]) else $error("buffer word left its block");
	a_buf_count: assert property (s_rise(fpc_pkg::OP_BUF_PROGRAM, 2) |-> dq_out == 16'(count_reg))
		else $error("buffer count write wrong");
	a_buf_words: assert property (s_rise(fpc_pkg::OP_BUF_PROGRAM, 4)
		|-> wb_cnt_reg == {1'b0, count_reg} + (IW + 1)'(1) && dq_out[7:0] == `FPC_CMD_CONFIRM)
		else $error("confirm not after N+1 words");
	a_clear_first: assert property (accept && wop == fpc_pkg::OP_BUF_PROGRAM && err_pend
		|-> ##[2:40] s_rise(fpc_pkg::OP_BUF_PROGRAM, 0)) else $error("no clear before buffered program");
	a_susp_gate: assert property (accept && wop == fpc_pkg::OP_SUSPEND
		|-> run_reg inside {fpc_pkg::RUN_ERASE, fpc_pkg::RUN_PROG}) else $error("suspend sent while idle");
	a_resume_fix: assert property (s_rise(fpc_pkg::OP_RESUME, 0) |-> dq_out[7:0] == `FPC_CMD_READ_ARRAY
		##[1:40] s_rise(fpc_pkg::OP_RESUME, 1)) else $error("resume not after read array");
	a_refuse_flag: assert property (refuse_ev |=> refused_reg && ($stable(state_reg) || $past(!is_idle)))
		else $error("refused command not flagged");
	a_reset_pin: assert property ($fell(reset) |-> !reset_powerdown_pin_n[*8])
		else $error("reset pulse too short");
endmodule // fpc_host

// *** fpc_pkg.sv ***
package fpc_pkg;

	typedef enum logic [3:0] {
		OP_READ_ARRAY, OP_READ_STATUS, OP_CLEAR_STATUS, OP_ERASE,
		OP_PROGRAM, OP_BUF_PROGRAM, OP_SUSPEND, OP_RESUME,
		OP_PROTECT, OP_UNPROTECT, OP_PREG_PROGRAM, OP_POLL
	} fpc_op_e;

	typedef enum logic [2:0] {
		K_END, K_SKIP, K_WC, K_WD, K_WN, K_WB, K_RD, K_POLL
	} fpc_kind_e;

	typedef enum logic [1:0] {RUN_NONE, RUN_ERASE, RUN_PROG, RUN_LOCK} fpc_run_e;

	typedef enum logic [2:0] {
		ST_RST, ST_IDLE, ST_CMD, ST_LOAD, ST_WLOW, ST_WHIGH, ST_RD
	} fpc_state_e;

	typedef struct packed {
		fpc_kind_e  kind;
		logic [7:0] code;
	} fpc_step_s;

endpackage
